// ===== pkg/twi_regs_pkg.sv
// Purpose: shared constants for the two-wire master interrupt and configuration registers
// Assumes: apb with 32-bit data, byte addresses, one aligned word per register
// Notes: reserved bits read as zero
package twi_regs_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [11:0] OFF_IRQ_MASK = 12'h010;
   localparam logic [11:0] OFF_RAW_STATUS = 12'h014;
   localparam logic [11:0] OFF_MASKED_STATUS = 12'h018;
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h01c;
   localparam logic [11:0] OFF_UNIT_CONFIG = 12'h020;

   // field positions
   localparam int MASK_BIT = 0;
   localparam int RAW_BIT = 0;
   localparam int MASKED_BIT = 0;
   localparam int CFG_LOOPBACK_BIT = 0;
   localparam int CFG_MASTER_EN_BIT = 4;
   localparam int CFG_SLAVE_EN_BIT = 5;

   // reset values
   localparam logic RST_MASK = 1'b0;
   localparam logic RST_RAW = 1'b0;
   localparam logic RST_LOOPBACK = 1'b0;
   localparam logic RST_MASTER_EN = 1'b0;
   localparam logic RST_SLAVE_EN = 1'b0;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;

   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;

   // line index into the pin vectors
   localparam int LINE_SDA = 0;
   localparam int LINE_SCL = 1;
   localparam int LINE_CNT = 2;

endpackage

// ===== rtl/line_sync.sv
// Purpose: two-flop synchroniser with edge detection and an internal bypass source
// Assumes: async_in comes from a pin; bypass_val is on sys_clk
// Notes: first flop feeds only the second flop
`timescale 1ns/10ps
module line_sync (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // pin side
   input wire logic async_in,
   // internal source used in loopback
   input wire logic bypass_en,
   input wire logic bypass_val,
   // observed line
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta_ff;
   logic sync_ff;
   logic last_ff;
   logic nxt_meta;
   logic nxt_sync;
   logic nxt_last;
   logic seen;

   // idle two-wire line rests high
   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
      seen = bypass_en ? bypass_val : sync_ff;
      nxt_last = seen;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         last_ff <= 1'b1;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         last_ff <= nxt_last;
      end
   end

   assign level = last_ff;
   assign rise = seen & ~last_ff;
   assign fall = ~seen & last_ff;

endmodule

// ===== rtl/twi_irq_config.sv
// Purpose: interrupt status, clear and unit configuration registers of a two-wire master
// Assumes: raw_event is a one-cycle pulse from the transfer engine on sys_clk
// Notes: zero-wait apb slave; read data is captured in the setup cycle
`timescale 1ns/10ps

// Functional notes
// - masked status bit 0 shows signalled interrupt
// - a clear-register write drops raw flag unless raw_event pulses in the same cycle
// - config bits 5,4 enable slave, master
// - config bit 0 selects internal loopback
// - mask bit gates raw onto interrupt
// - raw status bit 0 ignores mask
module twi_irq_config (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transfer engine
   input wire logic raw_event,
   input wire logic engine_scl_low,
   input wire logic engine_sda_low,
   output logic [1:0] line_level,
   output logic [1:0] line_rise,
   output logic [1:0] line_fall,
   // unit controls
   output logic master_function_enable,
   output logic slave_function_enable,
   output logic internal_loopback_test,
   output logic master_irq,
   // two-wire pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);

   logic raw_irq_flag_ff;
   logic irq_mask_ff;
   logic loopback_ff;
   logic master_en_ff;
   logic slave_en_ff;
   logic [31:0] rdata_ff;
   logic nxt_raw_irq_flag;
   logic nxt_irq_mask;
   logic nxt_loopback;
   logic nxt_master_en;
   logic nxt_slave_en;
   logic [31:0] nxt_rdata;
   logic masked_irq_flag;
   logic wr_commit;
   logic setup_read;
   logic [1:0] pin_in;
   logic [1:0] drive_low;

   // true when the offset lands on a mapped register
   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a == twi_regs_pkg::OFF_IRQ_MASK) || (a == twi_regs_pkg::OFF_RAW_STATUS)
         || (a == twi_regs_pkg::OFF_MASKED_STATUS) || (a == twi_regs_pkg::OFF_IRQ_CLEAR)
         || (a == twi_regs_pkg::OFF_UNIT_CONFIG);
   endfunction

   assign masked_irq_flag = raw_irq_flag_ff & irq_mask_ff;

   assign master_irq = masked_irq_flag;

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit(paddr);
   assign wr_commit = psel & penable & pwrite & addr_hit(paddr);
   assign setup_read = psel & ~penable & ~pwrite;

   // register state
   always_comb begin
      nxt_irq_mask = irq_mask_ff;
      nxt_loopback = loopback_ff;
      nxt_master_en = master_en_ff;
      nxt_slave_en = slave_en_ff;
      nxt_raw_irq_flag = raw_irq_flag_ff;
      if (wr_commit && paddr == twi_regs_pkg::OFF_IRQ_CLEAR) begin
         nxt_raw_irq_flag = 1'b0;
      end
      // new event beats a simultaneous clear
      if (raw_event) begin
         nxt_raw_irq_flag = 1'b1;
      end
      if (wr_commit && pstrb[0] && paddr == twi_regs_pkg::OFF_IRQ_MASK) begin
         nxt_irq_mask = pwdata[twi_regs_pkg::MASK_BIT];
      end
      if (wr_commit && pstrb[0] && paddr == twi_regs_pkg::OFF_UNIT_CONFIG) begin
         nxt_slave_en = pwdata[twi_regs_pkg::CFG_SLAVE_EN_BIT];
         nxt_master_en = pwdata[twi_regs_pkg::CFG_MASTER_EN_BIT];
         nxt_loopback = pwdata[twi_regs_pkg::CFG_LOOPBACK_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         raw_irq_flag_ff <= twi_regs_pkg::RST_RAW;
         irq_mask_ff <= twi_regs_pkg::RST_MASK;
         loopback_ff <= twi_regs_pkg::RST_LOOPBACK;
         master_en_ff <= twi_regs_pkg::RST_MASTER_EN;
         slave_en_ff <= twi_regs_pkg::RST_SLAVE_EN;
      end else begin
         raw_irq_flag_ff <= nxt_raw_irq_flag;
         irq_mask_ff <= nxt_irq_mask;
         loopback_ff <= nxt_loopback;
         master_en_ff <= nxt_master_en;
         slave_en_ff <= nxt_slave_en;
      end
   end

   // read data, captured at setup so prdata comes from a flop
   always_comb begin
      nxt_rdata = rdata_ff;
      if (setup_read) begin
         nxt_rdata = 32'h0000_0000;
         case (paddr)
            twi_regs_pkg::OFF_IRQ_MASK: begin
               nxt_rdata[twi_regs_pkg::MASK_BIT] = irq_mask_ff;
            end
            twi_regs_pkg::OFF_RAW_STATUS: begin
               nxt_rdata[twi_regs_pkg::RAW_BIT] = raw_irq_flag_ff;
            end
            twi_regs_pkg::OFF_MASKED_STATUS: begin
               nxt_rdata[twi_regs_pkg::MASKED_BIT] = masked_irq_flag;
            end
            twi_regs_pkg::OFF_UNIT_CONFIG: begin
               nxt_rdata[twi_regs_pkg::CFG_SLAVE_EN_BIT] = slave_en_ff;
               nxt_rdata[twi_regs_pkg::CFG_MASTER_EN_BIT] = master_en_ff;
               nxt_rdata[twi_regs_pkg::CFG_LOOPBACK_BIT] = loopback_ff;
            end
            default: begin
               nxt_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= twi_regs_pkg::RST_RDATA;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign prdata = rdata_ff;
   assign master_function_enable = master_en_ff;
   assign slave_function_enable = slave_en_ff;
   assign internal_loopback_test = loopback_ff;

   // pins released in loopback so the bus is never disturbed by a self-test
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = engine_scl_low & ~loopback_ff & (master_en_ff | slave_en_ff);
   assign sda_oe = engine_sda_low & ~loopback_ff & (master_en_ff | slave_en_ff);

   assign pin_in[twi_regs_pkg::LINE_SCL] = scl_i;
   assign pin_in[twi_regs_pkg::LINE_SDA] = sda_i;
   assign drive_low[twi_regs_pkg::LINE_SCL] = engine_scl_low;
   assign drive_low[twi_regs_pkg::LINE_SDA] = engine_sda_low;

   generate
      for (genvar g = 0; g < twi_regs_pkg::LINE_CNT; g++) begin : g_line
         line_sync u_sync (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .async_in(pin_in[g]),
            .bypass_en(loopback_ff),
            .bypass_val(~drive_low[g]),
            .level(line_level[g]),
            .rise(line_rise[g]),
            .fall(line_fall[g])
         );
      end
   endgenerate

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_write(logic [11:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence

   sequence s_read(logic [11:0] a);
      psel && !penable && !pwrite && paddr == a ##1 psel && penable;
   endsequence

   property p_masked_read;
      logic exp;
      (1, exp = masked_irq_flag) ##0 s_read(twi_regs_pkg::OFF_MASKED_STATUS) |->
         prdata[0] == exp && prdata[31:1] == 31'h0000_0000;
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("masked status read wrong");

   property p_clear;
      s_write(twi_regs_pkg::OFF_IRQ_CLEAR) ##0 !raw_event |=> !raw_irq_flag_ff ##0 !master_irq;
   endproperty
   a_clear: assert property (p_clear) else $error("clear write left raw flag set");

   property p_set_wins;
      raw_event |=> raw_irq_flag_ff;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");

   property p_cfg_write;
      s_write(twi_regs_pkg::OFF_UNIT_CONFIG) ##0 pstrb[0] |=>
         slave_function_enable == $past(pwdata[5]) && master_function_enable == $past(pwdata[4]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config enables not written");

   property p_cfg_hold;
      !(psel && penable && pwrite) |=> $stable(master_function_enable) && $stable(slave_function_enable)
         && $stable(internal_loopback_test);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

   property p_loop;
      (internal_loopback_test && $stable(engine_scl_low)) [*2] |->
         line_level[1] == !engine_scl_low && !scl_oe && !sda_oe;
   endproperty
   a_loop: assert property (p_loop) else $error("loopback path wrong");

   property p_mask;
      !irq_mask_ff |-> !master_irq;
   endproperty
   a_mask: assert property (p_mask) else $error("irq raised while masked");

   property p_raw_read;
      logic exp;
      (1, exp = raw_irq_flag_ff) ##0 s_read(twi_regs_pkg::OFF_RAW_STATUS) |-> prdata == {31'h0, exp};
   endproperty
   a_raw_read: assert property (p_raw_read) else $error("raw status read wrong");

   property p_masked_and;
      raw_irq_flag_ff && irq_mask_ff |-> master_irq ##1 (master_irq || !raw_irq_flag_ff || !irq_mask_ff);
   endproperty
   a_masked_and: assert property (p_masked_and) else $error("masked flag not raw and mask");

   property p_unmapped;
      psel && penable && !addr_hit(paddr) |-> pslverr && pready;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

   property p_mask_write;
      s_write(twi_regs_pkg::OFF_IRQ_MASK) ##0 (pstrb[0] && !pwdata[twi_regs_pkg::MASK_BIT]) |=> !master_irq;
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("irq kept after mask cleared");

   property p_mask_read;
      logic exp;
      (1, exp = irq_mask_ff) ##0 s_read(twi_regs_pkg::OFF_IRQ_MASK) |-> prdata == {31'h0000_0000, exp};
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

   property p_cfg_read;
      logic [2:0] exp;
      (1, exp = {slave_en_ff, master_en_ff, loopback_ff}) ##0 s_read(twi_regs_pkg::OFF_UNIT_CONFIG) |->
         prdata == {26'h000_0000, exp[2:1], 3'h0, exp[0]};
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

   property p_clear_read;
      s_read(twi_regs_pkg::OFF_IRQ_CLEAR) |-> prdata == 32'h0000_0000;
   endproperty
   a_clear_read: assert property (p_clear_read) else $error("clear register read not zero");

   property p_oe_off;
      !master_function_enable && !slave_function_enable |-> !scl_oe && !sda_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pins driven while disabled");

   property p_loop_sda;
      (internal_loopback_test && $stable(engine_sda_low)) [*2] |-> line_level[0] == !engine_sda_low;
   endproperty
   a_loop_sda: assert property (p_loop_sda) else $error("loopback data path wrong");

   // a refused write must leave every control as it was
   property p_unmapped_hold;
      psel && penable && pwrite && !addr_hit(paddr) |=> $stable(master_function_enable)
         && $stable(slave_function_enable) && $stable(internal_loopback_test) && $stable(irq_mask_ff);
   endproperty
   a_unmapped_hold: assert property (p_unmapped_hold) else $error("refused write changed state");

   property p_rdata_hold;
      !(psel && !penable && !pwrite) |=> $stable(prdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

endmodule

// ===== sim/i2c_master_irq_and_config_bench.sv
// Purpose: self-checking bench for the interrupt and configuration registers
// Assumes: zero-wait apb slave, one word per register
// Notes: link clock from the peer model, 400 ns period
`timescale 1ns/10ps
module i2c_master_irq_and_config_bench;
   logic sys_clk, arst_n, psel, penable, pwrite, raw_event, engine_scl_low, engine_sda_low;
   logic clk_run, hold_sda, pready, pslverr, master_function_enable, slave_function_enable;
   logic internal_loopback_test, master_irq, scl_o, scl_oe, sda_o, sda_oe, scl_line, sda_line;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [1:0] line_level, line_rise, line_fall;
   int failures, total_checks;

   twi_irq_config twi_irq_config_inst (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .raw_event(raw_event), .engine_scl_low(engine_scl_low),
      .engine_sda_low(engine_sda_low), .line_level(line_level), .line_rise(line_rise),
      .line_fall(line_fall), .master_function_enable(master_function_enable),
      .slave_function_enable(slave_function_enable), .internal_loopback_test(internal_loopback_test),
      .master_irq(master_irq), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe));
   twi_bus_peer twi_bus_peer_inst (.scl_oe(scl_oe), .sda_oe(sda_oe), .clk_run(clk_run),
      .hold_sda(hold_sda), .scl_line(scl_line), .sda_line(sda_line));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("failures %0d total_checks %0d", failures, total_checks);
      if (failures == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk(e, 1'b0);
   endtask

   task automatic t_reset;
      rd_chk(twi_regs_pkg::OFF_MASKED_STATUS, 32'h0);
      rd_chk(twi_regs_pkg::OFF_RAW_STATUS, 32'h0);
      rd_chk(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h0);
      chk(master_irq, 1'b0);
   endtask

   task automatic t_irq;
      @(posedge sys_clk);
      raw_event <= 1'b1;
      @(posedge sys_clk);
      raw_event <= 1'b0;
      rd_chk(twi_regs_pkg::OFF_RAW_STATUS, 32'h1);
      rd_chk(twi_regs_pkg::OFF_MASKED_STATUS, 32'h0);
      chk(master_irq, 1'b0);
      wr(twi_regs_pkg::OFF_IRQ_MASK, 32'h1);
      rd_chk(twi_regs_pkg::OFF_IRQ_MASK, 32'h1);
      wr(twi_regs_pkg::OFF_MASKED_STATUS, 32'h0);
      rd_chk(twi_regs_pkg::OFF_MASKED_STATUS, 32'h1);
      chk(master_irq, 1'b1);
      wr(twi_regs_pkg::OFF_IRQ_CLEAR, 32'h0);
      rd_chk(twi_regs_pkg::OFF_RAW_STATUS, 32'h0);
      rd_chk(twi_regs_pkg::OFF_MASKED_STATUS, 32'h0);
      chk(master_irq, 1'b0);
      wr(twi_regs_pkg::OFF_IRQ_MASK, 32'h0);
   endtask

   task automatic t_config;
      logic [31:0] v [4] = '{32'h20, 32'h10, 32'h01, 32'hffff_ffff};
      foreach (v[i]) begin
         wr(twi_regs_pkg::OFF_UNIT_CONFIG, v[i]);
         rd_chk(twi_regs_pkg::OFF_UNIT_CONFIG, v[i] & 32'h31);
         chk({slave_function_enable, master_function_enable, internal_loopback_test},
            {v[i][5], v[i][4], v[i][0]});
      end
   endtask

   task automatic t_lines;
      wr(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h11);
      engine_scl_low <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk({line_level[twi_regs_pkg::LINE_SCL], scl_oe, scl_line, scl_o}, 4'b0010);
      engine_scl_low <= 1'b0;
      wr(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h10);
      engine_sda_low <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk({sda_oe, sda_o, line_level[twi_regs_pkg::LINE_SDA]}, 3'b100);
      wr(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h0);
      // enables drop at the access edge, so look one edge later
      @(posedge sys_clk);
      chk(sda_oe, 1'b0);
      engine_sda_low <= 1'b0;
      hold_sda <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(line_fall[twi_regs_pkg::LINE_SDA], 1'b1);
      @(posedge sys_clk);
      chk(line_level[twi_regs_pkg::LINE_SDA], 1'b0);
      hold_sda <= 1'b0;
   endtask

   task automatic t_link;
      int rises;
      int falls;
      rises = 0;
      falls = 0;
      clk_run <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (i == 30) clk_run <= 1'b0;
         if (line_rise[twi_regs_pkg::LINE_SCL] === 1'b1) rises++;
         if (line_fall[twi_regs_pkg::LINE_SCL] === 1'b1) falls++;
      end
      chk(rises, 4);
      chk(falls, 4);
   endtask

   task automatic t_unmapped;
      logic [31:0] q;
      logic e;
      wr(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h20);
      apb(1'b1, 12'h024, 32'h11, q, e);
      chk(e, 1'b1);
      apb(1'b0, 12'h024, 32'h0, q, e);
      chk(q, 32'h0);
      chk(e, 1'b1);
      rd_chk(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h20);
      // low byte strobe off: the write must not land
      pstrb <= 4'he;
      wr(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h11);
      pstrb <= 4'hf;
      rd_chk(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h20);
      // reset in mid-run must drop the configuration
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd_chk(twi_regs_pkg::OFF_UNIT_CONFIG, 32'h0);
   endtask

   initial begin
      {arst_n, psel, penable, pwrite, raw_event, engine_scl_low, engine_sda_low, clk_run, hold_sda} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      failures = 0;
      total_checks = 0;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset();
      t_irq();
      t_config();
      t_lines();
      t_link();
      t_unmapped();
      end_sim();
   end

   // cuts a hang well past the expected run
   initial begin
      #200000;
      failures++;
      end_sim();
   end
endmodule

// ===== sim/twi_bus_peer.sv
// Purpose: far side of the two-wire bus, another master clocking scl and holding sda
// Assumes: open-drain lines with pull-ups, dut drives low while its enable is high
// Notes: scl runs only while clk_run is high, so the line idles released
`timescale 1ns/10ps
module twi_bus_peer (
   // dut pin drive
   input wire logic scl_oe,
   input wire logic sda_oe,
   // peer controls
   input wire logic clk_run,
   input wire logic hold_sda,
   // resolved lines
   output logic scl_line,
   output logic sda_line
);
   logic peer_scl_low;
   initial begin
      peer_scl_low = 1'b0;
      forever begin
         wait (clk_run);
         // odd offset keeps the link phase unrelated to sys_clk
         #37;
         peer_scl_low = 1'b1;
         #200;
         peer_scl_low = 1'b0;
         #163;
      end
   end
   // wired-and with pull-ups
   assign scl_line = ~(scl_oe | peer_scl_low);
   assign sda_line = ~(sda_oe | hold_sda);
endmodule
